// File: verilog/ecc_pkg.sv
// Constants shared by the endpoint-zero control transfer configuration block.
package ecc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ECC_OFS_BUF_CFG = 8'h28;
    localparam logic [7:0] ECC_OFS_MAX_PKT = 8'h2a;
    localparam logic [7:0] ECC_OFS_AUTO = 8'h2c;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ECC_BIT_RD_CONT = 15;
    localparam int ECC_POS_RD_BUF = 8;
    localparam int ECC_BIT_WR_CONT = 7;
    localparam int ECC_POS_WR_BUF = 0;
    localparam int ECC_BIT_AUTO_CFG = 1;
    localparam int ECC_BIT_AUTO_ADDR = 0;
    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] ECC_RST_BUF_CFG = 16'h0000;
    localparam logic [6:0] ECC_RST_MAX_PKT = 7'h08;
    localparam logic [1:0] ECC_RST_AUTO = 2'h0;
    localparam logic [5:0] ECC_BUF_LAST = 6'h2f;
    localparam logic [6:0] ECC_ADDR_MIN = 7'h01;
    // ------------------------------------------------------------
    // Request codes, states and response codes
    // ------------------------------------------------------------
    localparam logic [7:0] ECC_REQ_SET_ADDR = 8'h05;
    localparam logic [7:0] ECC_REQ_SET_CFG = 8'h09;
    typedef enum logic [2:0] {
        ECC_DEV_POWERED = 3'h0,
        ECC_DEV_DEFAULT = 3'h1,
        ECC_DEV_ADDRESS = 3'h3,
        ECC_DEV_CONFIGURED = 3'h2,
        ECC_DEV_SUSPENDED = 3'h6
    } ecc_dev_state_t;
    localparam logic [1:0] ECC_RSP_NAK = 2'h0;
    localparam logic [1:0] ECC_RSP_BUF = 2'h1;
endpackage : ecc_pkg

// File: verilog/ecc_auto_judge.sv
// Decision whether a setup request is answered by hardware.
`timescale 1ns/1ps
module ecc_auto_judge
    import ecc_pkg::*;
(
    input wire logic [7:0] req_code,
    input wire logic [15:0] req_value,
    input wire ecc_dev_state_t dev_state,
    input wire logic auto_addr_en,
    input wire logic auto_cfg_en,
    output logic auto_ok
);
    logic addr_ok;
    logic cfg_ok;
    always_comb begin
        addr_ok = auto_addr_en && req_code == ECC_REQ_SET_ADDR && dev_state == ECC_DEV_DEFAULT
            && req_value[15:7] == 9'h000 && req_value[6:0] >= ECC_ADDR_MIN;
        cfg_ok = auto_cfg_en && req_code == ECC_REQ_SET_CFG
            && ((dev_state == ECC_DEV_ADDRESS && req_value != 16'h0000)
            || (dev_state == ECC_DEV_CONFIGURED && req_value == 16'h0000));
        auto_ok = addr_ok || cfg_ok;
    end
endmodule : ecc_auto_judge

// File: verilog/ecc_ctl_cfg.sv
// Endpoint-zero buffer configuration, packet size and standard request auto-reply.
`timescale 1ns/1ps
module ecc_ctl_cfg
    import ecc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic setup_rcvd,
    input wire logic setup_done,
    input wire logic [7:0] req_code,
    input wire logic [15:0] req_value,
    input wire ecc_dev_state_t dev_state,
    input wire logic stage_event,
    input wire logic ctl_transfer_complete_bit,
    input wire logic ep0_code_wr,
    input wire logic [1:0] ep0_code_wdata,
    output logic [1:0] ep0_response_code,
    output logic ep0_force_nak,
    output logic ctl_read_continuous_en,
    output logic [5:0] ctl_read_buf_start,
    output logic [7:0] ctl_read_buf_last,
    output logic ctl_write_continuous_en,
    output logic [5:0] ctl_write_buf_start,
    output logic [7:0] ctl_write_buf_last,
    output logic [6:0] ep0_max_packet_bytes,
    output logic auto_reply_set_config_en,
    output logic auto_reply_set_addr_en,
    output logic auto_reply_active,
    output logic ctl_stage_interrupt,
    output logic ctl_transfer_done
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic rd_cont_q, rd_cont_d;
    logic wr_cont_q, wr_cont_d;
    logic [5:0] rd_buf_q, rd_buf_d;
    logic [5:0] wr_buf_q, wr_buf_d;
    logic [6:0] mxps_q, mxps_d;
    logic [1:0] auto_q, auto_d;
    logic [1:0] code_q, code_d;
    logic auto_busy_q, auto_busy_d;
    logic [15:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic done_q, done_d;
    logic auto_ok;

    ecc_auto_judge u_judge (
        .req_code(req_code),
        .req_value(req_value),
        .dev_state(dev_state),
        .auto_addr_en(auto_q[ECC_BIT_AUTO_ADDR]),
        .auto_cfg_en(auto_q[ECC_BIT_AUTO_CFG]),
        .auto_ok(auto_ok)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        rd_cont_d = rd_cont_q;
        wr_cont_d = wr_cont_q;
        rd_buf_d = rd_buf_q;
        wr_buf_d = wr_buf_q;
        mxps_d = mxps_q;
        auto_d = auto_q;
        code_d = code_q;
        auto_busy_d = auto_busy_q;
        irq_d = 1'b0;
        done_d = 1'b0;
        rdata_d = rdata_q;
        if (reg_wr) begin
            if (reg_addr == ECC_OFS_BUF_CFG) begin
                rd_cont_d = reg_wdata[ECC_BIT_RD_CONT];
                rd_buf_d = reg_wdata[ECC_POS_RD_BUF +: 6];
                wr_cont_d = reg_wdata[ECC_BIT_WR_CONT];
                wr_buf_d = reg_wdata[ECC_POS_WR_BUF +: 6];
            end else if (reg_addr == ECC_OFS_MAX_PKT) begin
                mxps_d = reg_wdata[6:0];
            end else if (reg_addr == ECC_OFS_AUTO) begin
                auto_d = reg_wdata[1:0];
            end
        end
        if (ep0_code_wr) begin
            code_d = ep0_code_wdata;
        end
        if (auto_busy_q && stage_event) begin
            done_d = 1'b1;
            auto_busy_d = 1'b0;
        end else if (!auto_busy_q && stage_event) begin
            irq_d = 1'b1;
        end
        if (setup_rcvd) begin
            code_d = ECC_RSP_NAK;
            auto_busy_d = 1'b0;
        end else if (setup_done && auto_ok) begin
            code_d = ECC_RSP_BUF;
            auto_busy_d = 1'b1;
        end
        if (!auto_busy_q && ctl_transfer_complete_bit) begin
            done_d = 1'b1;
        end
        if (reg_rd) begin
            if (reg_addr == ECC_OFS_BUF_CFG) begin
                rdata_d = {rd_cont_q, 1'b0, rd_buf_q, wr_cont_q, 1'b0, wr_buf_q};
            end else if (reg_addr == ECC_OFS_MAX_PKT) begin
                rdata_d = {9'h000, mxps_q};
            end else if (reg_addr == ECC_OFS_AUTO) begin
                rdata_d = {14'h0000, auto_q};
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_cont_q <= ECC_RST_BUF_CFG[ECC_BIT_RD_CONT];
            wr_cont_q <= ECC_RST_BUF_CFG[ECC_BIT_WR_CONT];
            rd_buf_q <= ECC_RST_BUF_CFG[13:8];
            wr_buf_q <= ECC_RST_BUF_CFG[5:0];
            mxps_q <= ECC_RST_MAX_PKT;
            auto_q <= ECC_RST_AUTO;
            code_q <= ECC_RSP_NAK;
            auto_busy_q <= 1'b0;
            rdata_q <= 16'h0000;
            irq_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            rd_cont_q <= rd_cont_d;
            wr_cont_q <= wr_cont_d;
            rd_buf_q <= rd_buf_d;
            wr_buf_q <= wr_buf_d;
            mxps_q <= mxps_d;
            auto_q <= auto_d;
            code_q <= code_d;
            auto_busy_q <= auto_busy_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            done_q <= done_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The continuous modes span four 64-byte blocks, so the last block is start plus three.
    always_comb begin
        ctl_read_buf_last = {2'b00, rd_buf_q} + (rd_cont_q ? 8'h03 : 8'h00);
        ctl_write_buf_last = {2'b00, wr_buf_q} + (wr_cont_q ? 8'h03 : 8'h00);
    end
    assign reg_rdata = rdata_q;
    assign ep0_response_code = code_q;
    assign ep0_force_nak = code_q == ECC_RSP_NAK;
    assign ctl_read_continuous_en = rd_cont_q;
    assign ctl_read_buf_start = rd_buf_q;
    assign ctl_write_continuous_en = wr_cont_q;
    assign ctl_write_buf_start = wr_buf_q;
    assign ep0_max_packet_bytes = mxps_q;
    assign auto_reply_set_config_en = auto_q[ECC_BIT_AUTO_CFG];
    assign auto_reply_set_addr_en = auto_q[ECC_BIT_AUTO_ADDR];
    assign auto_reply_active = auto_busy_q;
    assign ctl_stage_interrupt = irq_q;
    assign ctl_transfer_done = done_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_rd_cont_set;
        @(posedge clk) disable iff (reset)
        reg_wr && reg_addr == ECC_OFS_BUF_CFG |=> ctl_read_continuous_en == $past(reg_wdata[15]);
    endproperty
    a_rd_cont_set: assert property (p_rd_cont_set) else $error("read continuous bit not stored");
    property p_rd_buf;
        @(posedge clk) disable iff (reset)
        reg_wr && reg_addr == ECC_OFS_BUF_CFG |=> ctl_read_buf_start == $past(reg_wdata[13:8]);
    endproperty
    a_rd_buf: assert property (p_rd_buf) else $error("read buffer start not stored");
    property p_rd_span;
        @(posedge clk) disable iff (reset)
        ctl_read_continuous_en |-> ctl_read_buf_last == {2'b00, ctl_read_buf_start} + 8'h03;
    endproperty
    a_rd_span: assert property (p_rd_span) else $error("read span not four blocks");
    property p_wr_cont_set;
        @(posedge clk) disable iff (reset)
        reg_wr && reg_addr == ECC_OFS_BUF_CFG |=> ctl_write_continuous_en == $past(reg_wdata[7]);
    endproperty
    a_wr_cont_set: assert property (p_wr_cont_set) else $error("write continuous bit not stored");
    property p_wr_buf;
        @(posedge clk) disable iff (reset)
        reg_wr && reg_addr == ECC_OFS_BUF_CFG |=> ctl_write_buf_start == $past(reg_wdata[5:0]);
    endproperty
    a_wr_buf: assert property (p_wr_buf) else $error("write buffer start not stored");
    property p_wr_span;
        @(posedge clk) disable iff (reset)
        ctl_write_continuous_en |-> ctl_write_buf_last == {2'b00, ctl_write_buf_start} + 8'h03;
    endproperty
    a_wr_span: assert property (p_wr_span) else $error("write span not four blocks");
    property p_mxps;
        @(posedge clk) disable iff (reset)
        reg_wr && reg_addr == ECC_OFS_MAX_PKT |=> ep0_max_packet_bytes == $past(reg_wdata[6:0]);
    endproperty
    a_mxps: assert property (p_mxps) else $error("max packet size not stored");
    property p_auto_bits;
        @(posedge clk) disable iff (reset)
        reg_wr && reg_addr == ECC_OFS_AUTO |=>
            {auto_reply_set_config_en, auto_reply_set_addr_en} == $past(reg_wdata[1:0]);
    endproperty
    a_auto_bits: assert property (p_auto_bits) else $error("auto reply bits not stored");
    sequence s_auto_setup;
        setup_done && !setup_rcvd && auto_ok;
    endsequence
    property p_auto_buf;
        @(posedge clk) disable iff (reset)
        s_auto_setup |=> ep0_response_code == ECC_RSP_BUF && auto_reply_active;
    endproperty
    a_auto_buf: assert property (p_auto_buf) else $error("auto reply did not switch to buffer");
    property p_setup_nak;
        @(posedge clk) disable iff (reset)
        setup_rcvd |=> ep0_response_code == ECC_RSP_NAK && ep0_force_nak;
    endproperty
    a_setup_nak: assert property (p_setup_nak) else $error("setup did not force nak");
    property p_no_irq_auto;
        @(posedge clk) disable iff (reset)
        auto_reply_active && stage_event |=> !ctl_stage_interrupt && ctl_transfer_done;
    endproperty
    a_no_irq_auto: assert property (p_no_irq_auto) else $error("auto reply raised interrupt");
    property p_irq_manual;
        @(posedge clk) disable iff (reset)
        !auto_reply_active && stage_event |=> ctl_stage_interrupt;
    endproperty
    a_irq_manual: assert property (p_irq_manual) else $error("stage interrupt missing");
    property p_cfg_judge;
        @(posedge clk) disable iff (reset)
        req_code == ECC_REQ_SET_CFG && auto_ok |->
            (dev_state == ECC_DEV_ADDRESS && req_value != 16'h0000)
            || (dev_state == ECC_DEV_CONFIGURED && req_value == 16'h0000);
    endproperty
    a_cfg_judge: assert property (p_cfg_judge) else $error("bad config auto reply");
    property p_addr_judge;
        @(posedge clk) disable iff (reset)
        req_code == ECC_REQ_SET_ADDR && auto_ok |->
            dev_state == ECC_DEV_DEFAULT && req_value >= 16'h0001 && req_value <= 16'h007f;
    endproperty
    a_addr_judge: assert property (p_addr_judge) else $error("bad address auto reply");
    property p_reserved;
        @(posedge clk) disable iff (reset)
        reg_rd && reg_addr == ECC_OFS_AUTO |=> reg_rdata[15:2] == 14'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule : ecc_ctl_cfg

// File: testbench/ecc_host_model.sv
// Host-side model that plays the setup and stage events of a control transfer.
`timescale 1ns/1ps
module ecc_host_model
    import ecc_pkg::*;
(
    input wire logic clk,
    output logic setup_rcvd,
    output logic setup_done,
    output logic [7:0] req_code,
    output logic [15:0] req_value,
    output ecc_dev_state_t dev_state,
    output logic stage_event
);
    initial begin
        setup_rcvd = 1'b0;
        setup_done = 1'b0;
        stage_event = 1'b0;
        req_code = 8'h00;
        req_value = 16'h0000;
        dev_state = ECC_DEV_DEFAULT;
    end

    // Kind 0 is a setup packet, 1 the end of the setup transaction, 2 a stage change.
    // Request fields are only valid in the cycle of the pulse, so they are inverted afterwards.
    task automatic step(input logic [1:0] kind, input logic [7:0] code, input logic [15:0] value,
                        input ecc_dev_state_t st);
        @(posedge clk);
        setup_rcvd <= (kind == 2'h0);
        setup_done <= (kind == 2'h1);
        stage_event <= (kind == 2'h2);
        req_code <= code;
        req_value <= value;
        dev_state <= st;
        @(posedge clk);
        setup_rcvd <= 1'b0;
        setup_done <= 1'b0;
        stage_event <= 1'b0;
        req_code <= ~code;
        req_value <= ~value;
        #1;
    endtask : step
endmodule : ecc_host_model

// File: testbench/test_ecc_ctl_cfg.sv
// Self-checking bench for the endpoint-zero control configuration block.
`timescale 1ns/1ps
module test_ecc_ctl_cfg
    import ecc_pkg::*;
;
    logic clk, reset, reg_wr, reg_rd, ep0_code_wr, ep0_force_nak, ctl_transfer_complete_bit;
    logic [7:0] reg_addr, req_code, ctl_read_buf_last, ctl_write_buf_last;
    logic [15:0] reg_wdata, reg_rdata, req_value;
    logic [1:0] ep0_code_wdata, ep0_response_code;
    logic setup_rcvd, setup_done, stage_event, auto_reply_active, ctl_stage_interrupt, ctl_transfer_done;
    logic ctl_read_continuous_en, ctl_write_continuous_en, auto_reply_set_config_en, auto_reply_set_addr_en;
    logic [5:0] ctl_read_buf_start, ctl_write_buf_start;
    logic [6:0] ep0_max_packet_bytes;
    ecc_dev_state_t dev_state;
    int num_errors = 0;
    int check_count = 0;

    ecc_ctl_cfg dut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .setup_rcvd,
        .setup_done, .req_code, .req_value, .dev_state, .stage_event, .ctl_transfer_complete_bit,
        .ep0_code_wr, .ep0_code_wdata, .ep0_response_code, .ep0_force_nak, .ctl_read_continuous_en,
        .ctl_read_buf_start, .ctl_read_buf_last, .ctl_write_continuous_en, .ctl_write_buf_start,
        .ctl_write_buf_last, .ep0_max_packet_bytes, .auto_reply_set_config_en, .auto_reply_set_addr_en,
        .auto_reply_active, .ctl_stage_interrupt, .ctl_transfer_done);
    ecc_host_model host (.clk, .setup_rcvd, .setup_done, .req_code, .req_value, .dev_state, .stage_event);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic sw_code(input logic [1:0] c);
        @(posedge clk);
        ep0_code_wr <= 1'b1;
        ep0_code_wdata <= c;
        @(posedge clk);
        ep0_code_wr <= 1'b0;
        #1;
    endtask : sw_code

    // Setup, end of setup, a transfer-complete pulse and one stage change; hit says whether hardware answers alone.
    task automatic one_req(input logic [7:0] code, input logic [15:0] value, input ecc_dev_state_t st,
                           input logic hit);
        host.step(2'h0, code, value, st);
        chk(16'({ep0_response_code, ep0_force_nak}), 16'h0001);
        host.step(2'h1, code, value, st);
        chk(16'({ep0_response_code, auto_reply_active}), hit ? 16'h0003 : 16'h0000);
        @(posedge clk);
        ctl_transfer_complete_bit <= 1'b1;
        @(posedge clk);
        ctl_transfer_complete_bit <= 1'b0;
        #1;
        chk(16'(ctl_transfer_done), hit ? 16'h0000 : 16'h0001);
        host.step(2'h2, code, value, st);
        chk(16'({ctl_transfer_done, ctl_stage_interrupt, auto_reply_active}), hit ? 16'h0004 : 16'h0002);
    endtask : one_req

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(ECC_OFS_BUF_CFG, ECC_RST_BUF_CFG);
        rd(ECC_OFS_MAX_PKT, 16'(ECC_RST_MAX_PKT));
        rd(ECC_OFS_AUTO, 16'(ECC_RST_AUTO));
        chk(16'({ep0_response_code, ep0_force_nak}), 16'h0001);
        $display("Test reset values done");
    endtask : t_reset

    task automatic t_regs();
        wr(ECC_OFS_BUF_CFG, 16'hefef);
        rd(ECC_OFS_BUF_CFG, 16'hafaf);
        chk(16'({ctl_read_continuous_en, ctl_read_buf_start, ctl_write_continuous_en, ctl_write_buf_start}),
            16'h37ef);
        chk({ctl_read_buf_last, ctl_write_buf_last}, 16'h3232);
        wr(ECC_OFS_BUF_CFG, 16'h0510);
        chk({ctl_read_buf_last, ctl_write_buf_last}, 16'h0510);
        wr(ECC_OFS_MAX_PKT, 16'hffff);
        rd(ECC_OFS_MAX_PKT, 16'h007f);
        wr(ECC_OFS_MAX_PKT, 16'h0040);
        chk(16'(ep0_max_packet_bytes), 16'h0040);
        wr(ECC_OFS_AUTO, 16'hffff);
        rd(ECC_OFS_AUTO, 16'h0003);
        chk(16'({auto_reply_set_config_en, auto_reply_set_addr_en}), 16'h0003);
        wr(8'h2e, 16'hffff);
        rd(8'h2e, 16'h0000);
        $display("Test register access done");
    endtask : t_regs

    task automatic t_soft_code();
        sw_code(ECC_RSP_BUF);
        chk(16'({ep0_response_code, ep0_force_nak}), 16'h0002);
        sw_code(ECC_RSP_NAK);
        chk(16'({ep0_response_code, ep0_force_nak}), 16'h0001);
        sw_code(ECC_RSP_BUF);
        $display("Test software response code done");
    endtask : t_soft_code

    task automatic t_auto();
        one_req(ECC_REQ_SET_ADDR, 16'h0005, ECC_DEV_DEFAULT, 1'b1);
        one_req(ECC_REQ_SET_ADDR, 16'h007f, ECC_DEV_DEFAULT, 1'b1);
        one_req(ECC_REQ_SET_ADDR, 16'h0005, ECC_DEV_ADDRESS, 1'b0);
        one_req(ECC_REQ_SET_ADDR, 16'h0000, ECC_DEV_DEFAULT, 1'b0);
        one_req(ECC_REQ_SET_ADDR, 16'h0080, ECC_DEV_DEFAULT, 1'b0);
        one_req(ECC_REQ_SET_CFG, 16'h0001, ECC_DEV_ADDRESS, 1'b1);
        one_req(ECC_REQ_SET_CFG, 16'h0000, ECC_DEV_CONFIGURED, 1'b1);
        one_req(ECC_REQ_SET_CFG, 16'h0000, ECC_DEV_ADDRESS, 1'b0);
        one_req(ECC_REQ_SET_CFG, 16'h0001, ECC_DEV_CONFIGURED, 1'b0);
        one_req(ECC_REQ_SET_CFG, 16'h0001, ECC_DEV_DEFAULT, 1'b0);
        $display("Test auto reply cases done");
    endtask : t_auto

    task automatic t_auto_bits();
        wr(ECC_OFS_AUTO, 16'h0002);
        one_req(ECC_REQ_SET_ADDR, 16'h0005, ECC_DEV_DEFAULT, 1'b0);
        one_req(ECC_REQ_SET_CFG, 16'h0001, ECC_DEV_ADDRESS, 1'b1);
        wr(ECC_OFS_AUTO, 16'h0001);
        one_req(ECC_REQ_SET_CFG, 16'h0001, ECC_DEV_ADDRESS, 1'b0);
        one_req(ECC_REQ_SET_ADDR, 16'h0005, ECC_DEV_DEFAULT, 1'b1);
        $display("Test auto reply enables done");
    endtask : t_auto_bits

    task automatic complete_run();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        ep0_code_wr = 1'b0;
        ep0_code_wdata = 2'h0;
        ctl_transfer_complete_bit = 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_soft_code();
        t_auto();
        t_auto_bits();
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule : test_ecc_ctl_cfg
